// ==== core/prio_sleep_ctrl.sv ====
// priority split control and sleep / wake control with wishbone registers
// assumes: classic wishbone master on clk_i; pending and enable vectors and
// instruction strobes come from logic on clk_i; ext_event_i is an async pin
//
// Behaviour
// - split every priority level into group, subpriority
// - missing low priority bits count as zero
// - split value k: group 7..k+1, sub k..0
// - split value seven: no group, all subpriority
// - preemption compares group priority only
// - wake-any clear: only enabled interrupts wake
// - wake-any set: any new pending wakes
// - new pending raises wake event
// - event latched when not waiting for event
// - send-event or external event also wakes from wait-for-event
// - deep-sleep bit picks sleep or deep sleep
// - sleep-after-return bit sleeps on handler return
// - split select at bits 10:8, read/write
// - control write ignored without key in top half
`include "psc_map.svh"

module prio_sleep_ctrl
    import psc_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // priority compare
    input  wire logic        new_valid_i,
    input  wire prio_t       new_prio_i,
    input  wire logic        act_valid_i,
    input  wire prio_t       act_prio_i,
    output prio_t            group_o,
    output prio_t            sub_o,
    output logic             preempt_o,
    // processor events
    input  wire logic        wait_for_int_instr_i,
    input  wire logic        wait_for_event_instr_i,
    input  wire logic        send_event_instr_i,
    input  wire logic        handler_return_i,
    input  wire logic        ext_event_i,
    input  wire logic [7:0]  irq_pending_i,
    input  wire logic [7:0]  irq_enable_i,
    // power controller
    output logic             sleeping_o,
    output logic             deep_sleep_o,
    output logic             wake_o
);

    logic [2:0]   split_q;
    logic [31:0]  spc_q;
    sleep_state_t state_q;
    sleep_state_t state_d;
    logic         event_q;
    logic [7:0]   pend_q;
    logic [7:0]   pend_rise;
    logic         ext_meta_q;
    logic         ext_sync_q;
    logic         ext_prev_q;
    logic         ext_rise;
    logic         event_pulse;
    logic         irq_wake;
    logic         wfe_consume;
    logic         bus_req;
    logic         bus_wr;
    logic         irc_sel;
    logic         spc_sel;
    logic         stat_sel;
    logic         key_ok;

    // register decode, used by read and write paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    assign bus_req  = cyc_i && stb_i && !ack_o;
    assign bus_wr   = bus_req && we_i;
    assign irc_sel  = hit(adr_i, `PSC_IRC_OFF);
    assign spc_sel  = hit(adr_i, `PSC_SPC_OFF);
    assign stat_sel = hit(adr_i, `PSC_STAT_OFF);
    // key lives in the top half, so both upper lanes must be written
    assign key_ok   = (sel_i[3:2] == 2'b11) && (dat_i[31:16] == `PSC_KEY_WRITE);

    // single-cycle answer; unmapped addresses ack with zero data
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
        end
        else if (ce_i)
        begin
            ack_o <= bus_req;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dat_o <= 32'h0000_0000;
        end
        else if (ce_i && bus_req && !we_i)
        begin
            if (irc_sel)
            begin
                dat_o <= {`PSC_KEY_READ, 5'h00, split_q, 8'h00};
            end
            else if (spc_sel)
            begin
                dat_o <= spc_q & `PSC_SPC_MASK;
            end
            else if (stat_sel)
            begin
                dat_o <= {29'h0000_0000, event_q, deep_sleep_o, sleeping_o};
            end
            else
            begin
                dat_o <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            split_q <= `PSC_SPLIT_RST;
        end
        else if (ce_i && bus_wr && irc_sel && key_ok && sel_i[1])
        begin
            split_q <= dat_i[`PSC_SPLIT_LSB +: 3];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            spc_q <= `PSC_SPC_RST;
        end
        else if (ce_i && bus_wr && spc_sel && sel_i[0])
        begin
            spc_q <= {24'h00_0000, dat_i[7:0]} & `PSC_SPC_MASK;
        end
    end

    prio_split u_split
    (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .split_sel_i (split_q),
        .new_valid_i (new_valid_i),
        .new_prio_i  (new_prio_i),
        .act_valid_i (act_valid_i),
        .act_prio_i  (act_prio_i),
        .group_o     (group_o),
        .sub_o       (sub_o),
        .preempt_o   (preempt_o)
    );

    // external event pin: two-stage synchroniser, edge taken after it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end
        else if (ce_i)
        begin
            ext_meta_q <= ext_event_i;
            ext_sync_q <= ext_meta_q;
            ext_prev_q <= ext_sync_q;
        end
    end

    assign ext_rise = ext_sync_q && !ext_prev_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pend_q <= 8'h00;
        end
        else if (ce_i)
        begin
            pend_q <= irq_pending_i;
        end
    end

    assign pend_rise = irq_pending_i & ~pend_q;

    // disabled sources count only when wake-any is set
    assign event_pulse = send_event_instr_i || ext_rise ||
        |(pend_rise & (irq_enable_i | {8{spc_q[`PSC_WAKE_ANY_BIT]}}));
    assign irq_wake    = |(irq_pending_i & irq_enable_i);

    assign wfe_consume = (state_q == ST_RUN) && wait_for_event_instr_i;

    // an event arriving as a wait consumes it is used at once, never lost
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            event_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (event_pulse && !wfe_consume && state_q != ST_WFE)
            begin
                event_q <= 1'b1;
            end
            else if (wfe_consume)
            begin
                event_q <= 1'b0;
            end
        end
    end

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN:
            begin
                if (wait_for_int_instr_i)
                begin
                    state_d = ST_WFI;
                end
                else if (wait_for_event_instr_i)
                begin
                    state_d = (event_q || event_pulse) ? ST_RUN : ST_WFE;
                end
                else if (handler_return_i && spc_q[`PSC_SOE_BIT])
                begin
                    state_d = ST_WFI;
                end
            end
            ST_WFI:
            begin
                if (irq_wake || |(pend_rise & {8{spc_q[`PSC_WAKE_ANY_BIT]}}))
                begin
                    state_d = ST_RUN;
                end
            end
            ST_WFE:
            begin
                if (event_pulse)
                begin
                    state_d = ST_RUN;
                end
            end
            default:
            begin
                state_d = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= ST_RUN;
        end
        else if (ce_i)
        begin
            state_q <= state_d;
        end
    end

    // indications follow the next state so they match state_q each cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sleeping_o   <= 1'b0;
            deep_sleep_o <= 1'b0;
            wake_o       <= 1'b0;
        end
        else if (ce_i)
        begin
            sleeping_o   <= state_d != ST_RUN;
            deep_sleep_o <= (state_d != ST_RUN) &&
                            (state_q != ST_RUN ? deep_sleep_o : spc_q[`PSC_DEEP_BIT]);
            wake_o       <= (state_q != ST_RUN) && (state_d == ST_RUN);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_key_guard: assert property (ce_i && bus_wr && irc_sel && !key_ok |=>
        split_q == $past(split_q))
        else $error("control register written without key");
    a_split_write: assert property (ce_i && bus_wr && irc_sel && key_ok && sel_i[1] |=>
        split_q == $past(dat_i[10:8]))
        else $error("split select not written");
    a_power_reserved: assert property ((spc_q & ~`PSC_SPC_MASK) == 32'h0000_0000)
        else $error("power control reserved bits set");
    a_deep_follows: assert property ($rose(sleeping_o) |->
        deep_sleep_o == $past(spc_q[`PSC_DEEP_BIT]))
        else $error("deep sleep indication wrong on entry");
    a_deep_within: assert property (deep_sleep_o |-> sleeping_o)
        else $error("deep sleep shown while running");
    a_event_latch: assert property (ce_i && event_pulse && state_q == ST_RUN &&
        !wait_for_event_instr_i |=> event_q)
        else $error("event not latched");
    a_wfe_latched: assert property (ce_i && wfe_consume && event_q &&
        !wait_for_int_instr_i |=> !sleeping_o)
        else $error("wait for event slept despite latched event");
    a_wfe_wake: assert property (ce_i && state_q == ST_WFE && send_event_instr_i |=>
        !sleeping_o ##0 wake_o)
        else $error("send event did not wake");
    a_wake_any: assert property (ce_i && state_q == ST_WFE && spc_q[`PSC_WAKE_ANY_BIT] &&
        |pend_rise |=> !sleeping_o)
        else $error("new pending did not wake with wake-any");
    a_disabled_held: assert property (ce_i && state_q == ST_WFE &&
        !spc_q[`PSC_WAKE_ANY_BIT] && !send_event_instr_i && !ext_rise &&
        !(|(pend_rise & irq_enable_i)) |=> sleeping_o)
        else $error("disabled interrupt woke processor");
    a_pend_event: assert property (ce_i && state_q == ST_WFE &&
        |(pend_rise & irq_enable_i) |=> wake_o)
        else $error("pending interrupt gave no event");
    a_exit_sleep: assert property (ce_i && state_q == ST_RUN && handler_return_i &&
        !wait_for_int_instr_i && !wait_for_event_instr_i |=>
        sleeping_o == $past(spc_q[`PSC_SOE_BIT]))
        else $error("sleep after handler return wrong");
    a_ack_once: assert property (ce_i && ack_o |=> !ack_o)
        else $error("ack held two cycles");

    c_wfe_sleep: cover property (ce_i && state_q == ST_WFE ##[1:20] wake_o);
    c_deep: cover property (deep_sleep_o ##[1:20] wake_o);
    c_latched: cover property (event_q ##1 wfe_consume);
    c_key_write: cover property (ce_i && bus_wr && irc_sel && key_ok);
endmodule

// ==== core/prio_split.sv ====
// splits a priority level into group and subpriority, decides preemption
// assumes: same clock, reset and clock enable as the parent block
`include "psc_map.svh"

module prio_split
    import psc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // split setting
    input  wire logic [2:0] split_sel_i,
    // priorities to compare
    input  wire logic       new_valid_i,
    input  wire prio_t      new_prio_i,
    input  wire logic       act_valid_i,
    input  wire prio_t      act_prio_i,
    // results
    output prio_t           group_o,
    output prio_t           sub_o,
    output logic            preempt_o
);

    // group bits are 7 down to k+1; value 7 leaves no group bits
    function automatic prio_t group_mask(input logic [2:0] s);
        prio_t m;
        m = 8'h00;
        if (s != 3'h7)
        begin
            m = prio_t'(8'hFF << (s + 3'h1));
        end
        return m;
    endfunction

    prio_t new_impl;
    prio_t act_impl;
    prio_t gmask;

    // unimplemented low bits read as zero
    assign new_impl = new_prio_i & `PSC_PRIO_IMPL_MASK;
    assign act_impl = act_prio_i & `PSC_PRIO_IMPL_MASK;
    assign gmask    = group_mask(split_sel_i);

    // fields stay in place, not right-justified
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            group_o <= 8'h00;
            sub_o   <= 8'h00;
        end
        else if (ce_i)
        begin
            group_o <= new_impl & gmask;
            sub_o   <= new_impl & ~gmask;
        end
    end

    // lower group value wins; subpriority never preempts
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            preempt_o <= 1'b0;
        end
        else if (ce_i)
        begin
            preempt_o <= new_valid_i &&
                         (!act_valid_i || ((new_impl & gmask) < (act_impl & gmask)));
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_low_bits_zero: assert property ((sub_o & ~`PSC_PRIO_IMPL_MASK) == 8'h00)
        else $error("unimplemented priority bits not zero");
    a_split_zero: assert property (ce_i && split_sel_i == 3'h0 |=>
        group_o == ($past(new_prio_i) & 8'hF0) && sub_o == 8'h00)
        else $error("split select 0 gives wrong group");
    a_split_all_sub: assert property (ce_i && split_sel_i == 3'h7 |=> group_o == 8'h00)
        else $error("split select 7 left group bits");
    a_equal_group_no: assert property (ce_i && new_valid_i && act_valid_i &&
        (new_impl & gmask) == (act_impl & gmask) |=> !preempt_o)
        else $error("preemption on subpriority alone");
    a_split_sum: assert property ((group_o & sub_o) == 8'h00)
        else $error("group and subpriority overlap");

    c_preempt: cover property (ce_i && act_valid_i ##1 preempt_o);
endmodule

// ==== inc/psc_map.svh ====
// register map, field positions, reset values for the priority split / sleep block
// assumes: included by bare name from core files; byte addresses on a 32-bit wishbone
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

// register byte offsets
`define PSC_IRC_OFF        8'h00
`define PSC_SPC_OFF        8'h04
`define PSC_STAT_OFF       8'h08

// interrupt_reset_control fields
`define PSC_KEY_WRITE      16'h05FA
`define PSC_KEY_READ       16'hFA05
`define PSC_SPLIT_LSB      8
`define PSC_SPLIT_RST      3'h0

// system_power_control fields
`define PSC_WAKE_ANY_BIT   4
`define PSC_DEEP_BIT       2
`define PSC_SOE_BIT        1
`define PSC_SPC_MASK       32'h0000_0016
`define PSC_SPC_RST        32'h0000_0000

// status register fields
`define PSC_ST_SLEEP_BIT   0
`define PSC_ST_DEEP_BIT    1
`define PSC_ST_EVENT_BIT   2

// implemented priority bits: upper four of eight
`define PSC_PRIO_IMPL_MASK 8'hF0

`endif

// ==== inc/psc_pkg.sv ====
// types shared by the priority split and sleep control logic
// assumes: compiled before any core file
package psc_pkg;

    typedef logic [7:0] prio_t;

    typedef enum logic [2:0]
    {
        ST_RUN = 3'b001,
        ST_WFI = 3'b010,
        ST_WFE = 3'b100
    } sleep_state_t;

endpackage

// ==== tb/prio_sleep_ctrl_tb.sv ====
// self-checking bench for prio_sleep_ctrl: registers, priority split, sleep and wake
// assumes: classic wishbone single cycles, all stimulus on the rising edge of clk
`include "psc_map.svh"

module prio_sleep_ctrl_tb
    import psc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, rd, dat_o;
    logic        ack_o, preempt_o, sleeping_o, deep_sleep_o, wake_o;
    logic        nv = 1'b0, av = 1'b0, ext = 1'b0, ce = 1'b1;
    prio_t       np = 8'h00, ap = 8'h00, group_o, sub_o;
    logic [3:0]  ev = 4'h0;
    logic [7:0]  pend = 8'h00, ena = 8'h00, m, gn, ga;
    int          mismatches = 0, checked = 0, seed, n;

    always #4 clk = ~clk;

    prio_sleep_ctrl dut (
        .clk_i(clk), .rst_i(rst), .ce_i(ce),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
        .dat_o(dat_o), .ack_o(ack_o),
        .new_valid_i(nv), .new_prio_i(np), .act_valid_i(av), .act_prio_i(ap),
        .group_o(group_o), .sub_o(sub_o), .preempt_o(preempt_o),
        .wait_for_int_instr_i(ev[0]), .wait_for_event_instr_i(ev[1]),
        .send_event_instr_i(ev[2]), .handler_return_i(ev[3]), .ext_event_i(ext),
        .irq_pending_i(pend), .irq_enable_i(ena),
        .sleeping_o(sleeping_o), .deep_sleep_o(deep_sleep_o), .wake_o(wake_o)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // one classic cycle; read data taken at the edge that sees ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; dat <= d;
        // no local limit: only the watchdog ends a hung wait
        do
        begin
            @(posedge clk);
        end
        while (ack_o !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        wb(1'b0, a, 4'hF, 32'h0);
        chk(rd, exp, msg);
    endtask

    // one-cycle processor strobe: 0 wfi, 1 wfe, 2 sev, 3 handler return
    task automatic pulse(input int b);
        @(posedge clk) ev[b] <= 1'b1;
        @(posedge clk) ev[b] <= 1'b0;
        #1;
    endtask

    // bounded wait for the wake pulse, then sleep must be gone
    task automatic wait_wake(input int lim, input string msg);
        n = 0;
        while (wake_o !== 1'b1 && n < lim)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(wake_o, 1'b1, msg);
        chk(sleeping_o, 1'b0, msg);
    endtask

    task automatic done(input string name);
        $display("test %s done", name);
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        results();
    end

    initial
    begin
        seed = $urandom(32'hC4F4);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // reset values, key protection, unmapped place
        rdchk(`PSC_IRC_OFF, {`PSC_KEY_READ, 16'h0000}, "irc reset");
        rdchk(`PSC_SPC_OFF, 32'h0, "spc reset");
        wb(1'b1, `PSC_IRC_OFF, 4'hF, 32'h1234_0500);
        rdchk(`PSC_IRC_OFF, {`PSC_KEY_READ, 16'h0000}, "bad key");
        wb(1'b1, `PSC_IRC_OFF, 4'h7, {`PSC_KEY_WRITE, 16'h0500});
        rdchk(`PSC_IRC_OFF, {`PSC_KEY_READ, 16'h0000}, "partial lanes");
        wb(1'b1, `PSC_IRC_OFF, 4'hF, {`PSC_KEY_WRITE, 16'h0600});
        rdchk(`PSC_IRC_OFF, {`PSC_KEY_READ, 16'h0600}, "split write");
        wb(1'b1, `PSC_SPC_OFF, 4'hF, 32'hFFFF_FFFF);
        rdchk(`PSC_SPC_OFF, `PSC_SPC_MASK, "spc reserved");
        wb(1'b1, 8'h0C, 4'hF, 32'hFFFF_FFFF);
        rdchk(8'h0C, 32'h0, "unmapped");
        wb(1'b1, `PSC_SPC_OFF, 4'hF, 32'h0);
        done("registers");
        // every split value, random levels, equal levels first
        for (int k = 0; k < 8; k++)
        begin
            wb(1'b1, `PSC_IRC_OFF, 4'hF, {`PSC_KEY_WRITE, 5'h00, k[2:0], 8'h00});
            m = (k == 7) ? 8'h00 : (8'hFF << (k + 1));
            for (int j = 0; j < 6; j++)
            begin
                @(posedge clk);
                gn = 8'($urandom);
                np <= gn;
                ap <= (j == 0) ? gn : 8'($urandom);
                nv <= (j != 1);
                av <= (j != 2);
                repeat (3) @(posedge clk);
                #1;
                gn = np & `PSC_PRIO_IMPL_MASK & m;
                ga = ap & `PSC_PRIO_IMPL_MASK & m;
                chk(group_o, gn, "group");
                chk(sub_o, np & `PSC_PRIO_IMPL_MASK & ~m, "sub");
                chk(preempt_o, nv && (!av || gn < ga), "preempt");
            end
        end
        done("priority");
        // wait-for-event slept, woken by send-event
        pulse(1);
        chk(sleeping_o, 1'b1, "wfe sleep");
        pulse(2);
        chk(wake_o, 1'b1, "sev wake");
        chk(sleeping_o, 1'b0, "sev wake");
        @(posedge clk);
        #1;
        chk(wake_o, 1'b0, "wake one cycle");
        // event while running is remembered
        pulse(2);
        rdchk(`PSC_STAT_OFF, 32'h4, "latched");
        pulse(1);
        chk(sleeping_o, 1'b0, "latched wfe");
        repeat (2) @(posedge clk);
        #1;
        chk(sleeping_o, 1'b0, "latched wfe");
        // external pin wakes through its synchroniser
        pulse(1);
        chk(sleeping_o, 1'b1, "wfe sleep 2");
        @(posedge clk) ext <= 1'b1;
        wait_wake(8, "ext wake");
        @(posedge clk) ext <= 1'b0;
        done("events");
        // wake-any set, deep sleep: disabled pending wakes
        wb(1'b1, `PSC_SPC_OFF, 4'hF, 32'h14);
        pulse(1);
        chk(deep_sleep_o, 1'b1, "deep");
        @(posedge clk) pend <= 8'h08;
        wait_wake(4, "any pending");
        chk(deep_sleep_o, 1'b0, "deep off");
        // wake-any clear: disabled pending keeps sleeping
        wb(1'b1, `PSC_SPC_OFF, 4'hF, 32'h0);
        @(posedge clk) pend <= 8'h00;
        pulse(0);
        chk(sleeping_o, 1'b1, "wfi sleep");
        chk(deep_sleep_o, 1'b0, "plain sleep");
        @(posedge clk) pend <= 8'h20;
        repeat (6) @(posedge clk);
        #1;
        chk(sleeping_o, 1'b1, "disabled ignored");
        @(posedge clk) ena <= 8'h20;
        wait_wake(4, "enabled wakes");
        @(posedge clk) pend <= 8'h00;
        done("wake masks");
        // sleep after handler return, on and off
        wb(1'b1, `PSC_SPC_OFF, 4'h1, 32'h2);
        pulse(3);
        chk(sleeping_o, 1'b1, "return sleep");
        @(posedge clk) pend <= 8'h20;
        wait_wake(4, "return wake");
        @(posedge clk) pend <= 8'h00;
        wb(1'b1, `PSC_SPC_OFF, 4'h1, 32'h0);
        pulse(3);
        chk(sleeping_o, 1'b0, "return run");
        done("handler return");
        // latch from the return wake, then an enabled pending ends wfe
        pulse(1);
        chk(sleeping_o, 1'b0, "return latch");
        pulse(1);
        chk(sleeping_o, 1'b1, "wfe sleep 3");
        @(posedge clk) pend <= 8'h20;
        wait_wake(4, "pending event");
        @(posedge clk) pend <= 8'h00;
        // frozen clock enable: a send-event is not latched
        @(posedge clk) ce <= 1'b0;
        pulse(2);
        @(posedge clk) ce <= 1'b1;
        rdchk(`PSC_STAT_OFF, 32'h0, "frozen");
        // second reset in mid-run brings split select back to zero
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdchk(`PSC_IRC_OFF, {`PSC_KEY_READ, 16'h0000}, "irc reset 2");
        done("latch, enable, reset");
        results();
    end
endmodule
